// *** include/telemetry_readout_defs.svh ***
// offsets, field positions, reset values and code points of the telemetry readout registers
// assumes inclusion by bare name from the package and design files
//
// Functional notes
// - input current code is 12-bit unsigned in bits 15:4, low nibble reserved
// - current register read as two bytes: upper eight code bits, then low nibble on top
// - current code falls with sensed voltage: 0 V gives 0xF10, 1 V gives 0xB98
// - current conversion spans 0 to 1.38 V in 12 bits, 337 uV per step
// - input power is derived input voltage times sensed input current
// - power register read as two bytes: bits 15:8 first, then bits 7:0
// - local voltage code is 12-bit unsigned in bits 15:4, low nibble reserved
// - local voltage read as two bytes: eight MSBs, then four LSBs in top nibble
// - local voltage code rises from 0x000 at 0 V to 0xF7C at 1.5 V
// - one volt on the local sense pin gives local voltage code 0xA53
// - local voltage conversion spans 0 to 1.55 V in 12 bits, 378 uV per step
`ifndef TELEMETRY_READOUT_DEFS_SVH
`define TELEMETRY_READOUT_DEFS_SVH

// ==========================================================
// register offsets
`define OFS_INPUT_CURRENT   8'h13
`define OFS_INPUT_POWER     8'h14
`define OFS_LOCAL_VOLTAGE   8'h15

// ==========================================================
// field layout
`define CODE_WIDTH          12
`define RSVD_BITS           4
`define RSVD_VALUE          4'h0
`define UNMAPPED_DATA       8'h00

// ==========================================================
// conversion figures
`define CUR_SPAN_MV         1380
`define CUR_LSB_UV          337
`define CUR_CODE_0V         12'hF10
`define CUR_CODE_1V         12'hB98
`define VOLT_SPAN_MV        1550
`define VOLT_LSB_UV         378
`define VOLT_CODE_0V        12'h000
`define VOLT_CODE_1V        12'hA53
`define VOLT_CODE_1V5       12'hF7C
`define DVIN_RESET          16'h0000
`define POWER_SHIFT         12

`endif

// *** include/telemetry_readout_pkg.sv ***
// types shared by the telemetry readout design files
// assumes the defs header is on the include path
`default_nettype none
`include "telemetry_readout_defs.svh"

package telemetry_readout_pkg;

  typedef logic [7:0]  byte_t;
  typedef logic [15:0] word_t;
  typedef logic [`CODE_WIDTH-1:0] code_t;

  typedef enum logic [0:0] {
    PH_FIRST  = 1'b0,
    PH_SECOND = 1'b1
  } phase_e;

  typedef struct packed {
    code_t  cur;
    code_t  volt;
    word_t  dvin;
    word_t  hold;
    phase_e phase;
    byte_t  last_addr;
    byte_t  rd_data;
    logic   rd_valid;
  } readout_s;

  typedef struct packed {
    word_t power;
  } product_s;

endpackage
`default_nettype wire

// *** rtl/input_power_product.sv ***
// input power product: derived input voltage times input current code
// assumes both operands are registered in the same clock domain
`timescale 1ns/1ps
`default_nettype none
`include "telemetry_readout_defs.svh"

module input_power_product
  import telemetry_readout_pkg::*;
#(
  parameter int SHIFT = `POWER_SHIFT
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic [15:0] dvin,
  input  wire logic [11:0] cur,
  output logic      [15:0] power
);

  if (SHIFT < 0 || SHIFT > 27) begin : g_bad_shift
    $error("input_power_product: SHIFT out of range");
  end

  product_s    s_q;
  product_s    s_d;
  logic [27:0] full;

  // ==========================================================
  // product
  always_comb begin
    s_d = s_q;
    full = (28'(dvin) * 28'(cur)) >> SHIFT;
    if (|full[27:16]) begin
      s_d.power = 16'hFFFF;
    end else begin
      s_d.power = full[15:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_q.power <= 16'h0000;
    end else begin
      s_q <= s_d;
    end
  end

  assign power = s_q.power;

  // ==========================================================
  // checks
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  product_value_a : assert property (
    ($past(dvin) == 16'h0 || $past(cur) == 12'h0) |-> power == 16'h0000
  ) else $error("power not zero for zero operand");

  product_scale_a : assert property (
    (SHIFT < 16 && $past(dvin) == 16'(1 << SHIFT)) |-> power == 16'($past(cur))
  ) else $error("power does not follow current for unit voltage");

endmodule
`default_nettype wire

// *** rtl/telemetry_readout_regs.sv ***
// read-only telemetry registers with two-byte reads and a holding latch
// assumes converter codes and byte-read strobes arrive on clk_sys
`timescale 1ns/1ps
`default_nettype none
`include "telemetry_readout_defs.svh"

module telemetry_readout_regs
  import telemetry_readout_pkg::*;
#(
  parameter int POWER_SHIFT = `POWER_SHIFT
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic [11:0] current_code,
  input  wire logic        current_valid,
  input  wire logic [11:0] voltage_code,
  input  wire logic        voltage_valid,
  input  wire logic [15:0] derived_input_voltage,
  input  wire logic        derived_valid,
  input  wire logic        rd_req,
  input  wire logic [7:0]  rd_addr,
  output logic      [7:0]  rd_data,
  output logic             rd_valid,
  input  wire logic        wr_req,
  input  wire logic [7:0]  wr_addr,
  input  wire logic [7:0]  wr_data
);

  if (POWER_SHIFT < 0 || POWER_SHIFT > 27) begin : g_bad_shift
    $error("telemetry_readout_regs: POWER_SHIFT out of range");
  end

  readout_s s_q;
  readout_s s_d;
  word_t    power;
  word_t    word;

  // ==========================================================
  // decode
  function automatic logic is_mapped(input byte_t addr);
    return addr == `OFS_INPUT_CURRENT || addr == `OFS_INPUT_POWER ||
           addr == `OFS_LOCAL_VOLTAGE;
  endfunction

  function automatic word_t read_word(input byte_t addr, input code_t cur,
                                      input word_t pwr, input code_t volt);
    word_t w;
    w = 16'h0000;
    if (addr == `OFS_INPUT_CURRENT) begin
      w = {cur, `RSVD_VALUE};
    end else if (addr == `OFS_INPUT_POWER) begin
      w = pwr;
    end else if (addr == `OFS_LOCAL_VOLTAGE) begin
      w = {volt, `RSVD_VALUE};
    end
    return w;
  endfunction

  // ==========================================================
  // power product
  input_power_product #(
    .SHIFT (POWER_SHIFT)
  ) u_power (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .dvin    (s_q.dvin),
    .cur     (s_q.cur),
    .power   (power)
  );

  // ==========================================================
  // next state
  always_comb begin
    s_d = s_q;
    s_d.rd_valid = 1'b0;
    word = read_word(rd_addr, s_q.cur, power, s_q.volt);
    if (current_valid) begin
      s_d.cur = current_code;
    end
    if (voltage_valid) begin
      s_d.volt = voltage_code;
    end
    if (derived_valid) begin
      s_d.dvin = derived_input_voltage;
    end
    if (rd_req) begin
      s_d.rd_valid = 1'b1;
      if (s_q.phase == PH_SECOND && rd_addr == s_q.last_addr) begin
        s_d.rd_data = s_q.hold[7:0];
        s_d.phase   = PH_FIRST;
      end else if (is_mapped(rd_addr)) begin
        s_d.hold      = word;
        s_d.rd_data   = word[15:8];
        s_d.phase     = PH_SECOND;
        s_d.last_addr = rd_addr;
      end else begin
        s_d.rd_data = `UNMAPPED_DATA;
        s_d.phase   = PH_FIRST;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      // current code idles at zero input
      s_q.cur       <= `CUR_CODE_0V;
      s_q.volt      <= `VOLT_CODE_0V;
      s_q.dvin      <= `DVIN_RESET;
      s_q.hold      <= 16'h0000;
      s_q.phase     <= PH_FIRST;
      s_q.last_addr <= 8'h00;
      s_q.rd_data   <= 8'h00;
      s_q.rd_valid  <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rd_data  = s_q.rd_data;
  assign rd_valid = s_q.rd_valid;

  // ==========================================================
  // checks
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  read_answer_a : assert property (
    rd_req |=> rd_valid
  ) else $error("byte read not answered next cycle");

  cur_msb_a : assert property (
    (rd_req && rd_addr == `OFS_INPUT_CURRENT && s_q.phase == PH_FIRST)
      |=> rd_data == $past(s_q.cur[11:4])
  ) else $error("current first byte wrong");

  cur_lsb_a : assert property (
    (rd_req && rd_addr == `OFS_INPUT_CURRENT && s_q.phase == PH_FIRST)
      ##1 (rd_req && rd_addr == `OFS_INPUT_CURRENT)
      |=> rd_data == {$past(s_q.cur[3:0], 2), 4'h0}
  ) else $error("current second byte wrong");

  pwr_msb_a : assert property (
    (rd_req && rd_addr == `OFS_INPUT_POWER && s_q.phase == PH_FIRST)
      |=> rd_data == $past(power[15:8])
  ) else $error("power first byte wrong");

  pwr_lsb_a : assert property (
    (rd_req && rd_addr == `OFS_INPUT_POWER && s_q.phase == PH_FIRST)
      ##1 (rd_req && rd_addr == `OFS_INPUT_POWER)
      |=> rd_data == $past(power[7:0], 2)
  ) else $error("power second byte not from latch");

  volt_msb_a : assert property (
    (rd_req && rd_addr == `OFS_LOCAL_VOLTAGE && s_q.phase == PH_FIRST)
      |=> rd_data == $past(s_q.volt[11:4])
  ) else $error("voltage first byte wrong");

  volt_lsb_a : assert property (
    (rd_req && rd_addr == `OFS_LOCAL_VOLTAGE && s_q.phase == PH_FIRST)
      ##1 (rd_req && rd_addr == `OFS_LOCAL_VOLTAGE)
      |=> rd_data == {$past(s_q.volt[3:0], 2), 4'h0}
  ) else $error("voltage second byte wrong");

  unmapped_zero_a : assert property (
    (rd_req && !is_mapped(rd_addr) && s_q.phase == PH_FIRST)
      |=> rd_data == `UNMAPPED_DATA
  ) else $error("unmapped read not zero");

  write_ignored_a : assert property (
    (wr_req && !rd_req && !current_valid && !voltage_valid)
      |=> !rd_valid && $stable(s_q.phase) && $stable(s_q.cur) && $stable(s_q.volt)
  ) else $error("write had a side effect");

  cur_reset_a : assert property (
    $rose(rst_b) |-> s_q.cur == `CUR_CODE_0V && s_q.volt == `VOLT_CODE_0V
  ) else $error("idle codes wrong after reset");

  rd_pulse_a : assert property (
    !rd_req |=> !rd_valid
  ) else $error("read answer lasted more than one cycle");

  rd_hold_a : assert property (
    !rd_req |=> $stable(rd_data)
  ) else $error("read data changed without a read");

  second_clear_a : assert property (
    (rd_req && s_q.phase == PH_SECOND && rd_addr == s_q.last_addr)
      |=> s_q.phase == PH_FIRST
  ) else $error("second byte did not end the pair");

  new_pair_a : assert property (
    (rd_req && s_q.phase == PH_SECOND && rd_addr != s_q.last_addr && is_mapped(rd_addr))
      |=> s_q.phase == PH_SECOND && s_q.last_addr == $past(rd_addr)
  ) else $error("other register did not start a new pair");

  rsvd_zero_a : assert property (
    (s_q.phase == PH_SECOND && s_q.last_addr != `OFS_INPUT_POWER)
      |-> s_q.hold[`RSVD_BITS-1:0] == `RSVD_VALUE
  ) else $error("reserved bits of latched word not zero");

  cur_load_a : assert property (
    current_valid |=> s_q.cur == $past(current_code)
  ) else $error("current code not taken");

  volt_load_a : assert property (
    voltage_valid |=> s_q.volt == $past(voltage_code)
  ) else $error("voltage code not taken");

  dvin_load_a : assert property (
    derived_valid |=> s_q.dvin == $past(derived_input_voltage)
  ) else $error("derived input voltage not taken");

endmodule
`default_nettype wire

// *** verification/telemetry_host_model.sv ***
// host model: byte reads of the telemetry registers
// assumes rd_valid rises on the taking edge and is read at the negedge half a cycle later
`timescale 1ns/1ps
`default_nettype none
module telemetry_host_model
  import telemetry_readout_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_valid,
  output logic            rd_req,
  output logic      [7:0] rd_addr
);
  initial begin
    rd_req  = 1'b0;
    rd_addr = 8'h00;
  end
  // ==========================================================
  // byte and word reads
  task automatic rd_byte(input byte_t a, output byte_t b, output logic v);
    @(negedge clk_sys);
    rd_req  = 1'b1;
    rd_addr = a;
    @(negedge clk_sys);
    b       = rd_data;
    v       = rd_valid;
    rd_req  = 1'b0;
    rd_addr = ~a;
  endtask
  task automatic rd_word(input byte_t a, output word_t w, output logic v);
    logic v1;
    @(negedge clk_sys);
    rd_req  = 1'b1;
    rd_addr = a;
    @(negedge clk_sys);
    w[15:8] = rd_data;
    v1      = rd_valid;
    @(negedge clk_sys);
    w[7:0]  = rd_data;
    v       = rd_valid & v1;
    rd_req  = 1'b0;
    rd_addr = ~a;
  endtask
endmodule
`default_nettype wire

// *** verification/test_telemetry_readout_regs.sv ***
// bench for the telemetry readout registers
// assumes the host model drives the read port
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module test_telemetry_readout_regs
  import telemetry_readout_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        rst_b   = 1'b0;
  logic [11:0] current_code = 12'h000;
  logic        current_valid = 1'b0;
  logic [11:0] voltage_code = 12'h000;
  logic        voltage_valid = 1'b0;
  logic [15:0] dvin    = 16'h0000;
  logic        dvin_valid = 1'b0;
  logic        rd_req;
  logic [7:0]  rd_addr;
  logic [7:0]  rd_data;
  logic        rd_valid;
  logic        wr_req  = 1'b0;
  logic [7:0]  wr_addr = 8'h00;
  logic [7:0]  wr_data = 8'h00;
  int          error_cnt = 0;
  int          checks_done = 0;
  byte_t       b;
  byte_t       b2;
  logic        v;
  word_t       w;

  always #4 clk_sys = ~clk_sys;

  telemetry_readout_regs #(.POWER_SHIFT(12)) telemetry_readout_regs_inst (
    .clk_sys(clk_sys), .rst_b(rst_b), .current_code(current_code),
    .current_valid(current_valid), .voltage_code(voltage_code),
    .voltage_valid(voltage_valid), .derived_input_voltage(dvin),
    .derived_valid(dvin_valid), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_data(rd_data), .rd_valid(rd_valid), .wr_req(wr_req),
    .wr_addr(wr_addr), .wr_data(wr_data));

  telemetry_host_model telemetry_host_model_inst (
    .clk_sys(clk_sys), .rd_data(rd_data), .rd_valid(rd_valid),
    .rd_req(rd_req), .rd_addr(rd_addr));

  // ==========================================================
  // tasks
  task automatic load(input code_t c, input code_t vc, input word_t d);
    @(negedge clk_sys);
    {current_code, voltage_code, dvin} = {c, vc, d};
    {current_valid, voltage_valid, dvin_valid} = 3'b111;
    @(negedge clk_sys);
    {current_valid, voltage_valid, dvin_valid} = 3'b000;
  endtask
  task automatic wr(input byte_t a, input byte_t d);
    @(negedge clk_sys);
    {wr_req, wr_addr, wr_data} = {1'b1, a, d};
    @(negedge clk_sys);
    {wr_req, wr_addr, wr_data} = {1'b0, ~a, ~d};
  endtask
  task automatic chk_word(input byte_t a, input word_t e);
    telemetry_host_model_inst.rd_word(a, w, v);
    `CHK(w, e)
    `CHK(v, 1'b1)
  endtask
  task automatic final_report();
    $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ==========================================================
  // tests
  initial begin
    repeat (8) @(negedge clk_sys);
    rst_b = 1'b1;
    chk_word(8'h13, 16'hF100);
    chk_word(8'h15, 16'h0000);
    chk_word(8'h14, 16'h0000);
    $display("test reset done");
    load(12'hB98, 12'hA53, 16'h1000);
    chk_word(8'h13, 16'hB980);
    chk_word(8'h15, 16'hA530);
    chk_word(8'h14, 16'h0B98);
    load(12'hFFF, 12'hF7C, 16'hFFFF);
    chk_word(8'h13, 16'hFFF0);
    chk_word(8'h15, 16'hF7C0);
    chk_word(8'h14, 16'hFFEF);
    $display("test codes done");
    telemetry_host_model_inst.rd_byte(8'h15, b, v);
    load(12'h123, 12'h123, 16'h1000);
    telemetry_host_model_inst.rd_byte(8'h15, b2, v);
    `CHK(b, 8'hF7)
    `CHK(b2, 8'hC0)
    chk_word(8'h15, 16'h1230);
    $display("test latch done");
    wr(8'h15, 8'hFF);
    chk_word(8'h15, 16'h1230);
    telemetry_host_model_inst.rd_byte(8'h13, b, v);
    wr(8'h13, 8'hFF);
    telemetry_host_model_inst.rd_byte(8'h13, b2, v);
    `CHK({b, b2}, 16'h1230)
    $display("test write done");
    telemetry_host_model_inst.rd_byte(8'h15, b, v);
    chk_word(8'h13, 16'h1230);
    telemetry_host_model_inst.rd_byte(8'h16, b, v);
    `CHK(b, 8'h00)
    `CHK(v, 1'b1)
    chk_word(8'h14, 16'h0123);
    $display("test unmapped done");
    telemetry_host_model_inst.rd_byte(8'h13, b, v);
    @(negedge clk_sys);
    rst_b = 1'b0;
    @(negedge clk_sys);
    `CHK({rd_valid, rd_data}, 9'h000)
    @(negedge clk_sys);
    rst_b = 1'b1;
    chk_word(8'h13, 16'hF100);
    chk_word(8'h15, 16'h0000);
    chk_word(8'h14, 16'h0000);
    $display("test reset again done");
    final_report();
  end

  // ==========================================================
  // watchdog
  initial begin
    #20000;
    error_cnt++;
    final_report();
  end
endmodule
`default_nettype wire
